// *** src/aidiag_pkg.sv ***
// constants, field layouts and carrier types for the analog input status records
// What this block does
// - upper limit flags: bit 0 channel 0, bit 1 channel 1, rest reserved.
// - lower limit flags: bit 0 channel 0, bit 1 channel 1, rest reserved.
// - a 32-bit microsecond ticker starts at zero after power-on, counts up.
// - the ticker wraps from its maximum to zero, never saturates.
// - interrupt timestamp is the ticker's low 16 bits when interrupt is raised.
// - incoming diagnostic interrupt only when enabled; incoming one provides diagnostic record.
// - when the cause disappears a going interrupt follows without host action.
// - events between incoming and going interrupts are dropped, not queued.
// - fault LED lit from first incoming to last going interrupt.
// - diagnostic record byte order fixed, with constant bytes 15h, 71h, 08h, 02h.
// - host reads whole record, or its first four bytes via short access.
// - error byte A: failure, internal, external, channel, aux supply, parameter.
// - module info: class 0101b in bits 3..0, bit 4 channel info.
// - error byte D: bit 3 buffer overflow, bit 4 comm error, bit 6 lost.
// - channel group errors: bit 0 group 0, bit 1 group 1.
// - per-channel error byte bits: parameter, raw high/low, sensor, lost, range.
// - diagnostic timestamp holds the full ticker value at the event.
// - enabled limit crossing raises a hardware interrupt carrying the flag bytes, unless the last hardware record is still unread.
// - limit flags and interrupt timestamp reset to zero.
package aidiag_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICKER_BITS = 32;
  localparam int STAMP_BITS = 16;

  // ****************************************
  // record sets and sizes
  // ****************************************
  localparam logic [7:0] SET_SHORT = 8'h00;
  localparam logic [7:0] SET_DIAG = 8'h01;
  localparam logic [7:0] SET_HW = 8'h02;
  localparam int DIAG_BYTES = 20;
  localparam int SHORT_BYTES = 4;
  localparam int HW_BYTES = 4;

  // ****************************************
  // diagnostic record byte offsets
  // ****************************************
  localparam int OFS_ERR_A = 0;
  localparam int OFS_INFO = 1;
  localparam int OFS_RSVD = 2;
  localparam int OFS_ERR_D = 3;
  localparam int OFS_KIND = 4;
  localparam int OFS_DIAG_BITS_PER_CHANNEL = 5;
  localparam int OFS_CHANNEL_COUNT = 6;
  localparam int OFS_CHANNEL_GROUP_ERRORS = 7;
  localparam int OFS_CH0 = 8;
  localparam int OFS_STAMP = 16;

  // hardware interrupt record: upper, lower, stamp high, stamp low
  localparam int OFS_HW_UPPER = 0;
  localparam int OFS_HW_LOWER = 1;
  localparam int OFS_HW_STAMP_HI = 2;
  localparam int OFS_HW_STAMP_LO = 3;

  // ****************************************
  // reset and constant byte values
  // ****************************************
  localparam logic [7:0] MODULE_INFO = 8'h15;
  localparam logic [7:0] CHANNEL_KIND = 8'h71;
  localparam logic [7:0] DIAG_BITS = 8'h08;
  localparam logic [7:0] CHANNEL_COUNT = 8'h02;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int A_FAILURE = 0;
  localparam int A_INTERNAL = 1;
  localparam int A_EXTERNAL = 2;
  localparam int A_CHANNEL = 3;
  localparam int A_AUX = 4;
  localparam int A_PARAM = 7;
  localparam int D_BUF_OVF = 3;
  localparam int D_COMM = 4;
  localparam int D_LOST = 6;
  localparam int C_PARAM = 0;
  localparam int C_RAW_HIGH = 1;
  localparam int C_RAW_LOW = 2;
  localparam int C_SENSOR = 4;
  localparam int C_LOST = 5;
  localparam int C_UNDER = 6;
  localparam int C_OVER = 7;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic range_over;
    logic range_under;
    logic sensor_fault;
    logic raw_low;
    logic raw_high;
    logic param_error;
  } chan_fault_t;

  typedef struct packed {
    logic param_error;
    logic aux_missing;
    logic external_error;
    logic internal_error;
    logic module_failure;
    logic buffer_overflow;
    logic comm_error;
  } module_fault_t;

  typedef struct packed {
    logic [7:0] record_set_index;
    logic [7:0] object_subindex;
  } read_req_t;

  typedef enum logic [1:0] {
    DIAG_IDLE = 2'b01,
    DIAG_ACTIVE = 2'b10
  } diag_state_t;

endpackage : aidiag_pkg

// *** src/us_ticker.sv ***
// free-running microsecond ticker with its prescaler
module us_ticker #(
  parameter int PRESCALE = aidiag_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  output logic [aidiag_pkg::TICKER_BITS-1:0] count
);

  logic [15:0] prescale;

  if (PRESCALE < 1 || PRESCALE > 65536) begin : g_check
    $error("us_ticker: PRESCALE out of range");
  end

  always_ff @(posedge clk) begin
    if (sys_rst || prescale == 16'(PRESCALE - 1)) begin
      prescale <= 16'h0000;
    end else begin
      prescale <= prescale + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= 32'h0000_0000;
    end else if (prescale == 16'(PRESCALE - 1)) begin
      count <= count + 32'h0000_0001;
    end
  end

endmodule : us_ticker

// *** src/record_store.sv ***
// snapshot store for the diagnostic record, registered byte read
module record_store #(
  parameter int BYTES = aidiag_pkg::DIAG_BYTES,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [BYTES*8-1:0] load_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem [BYTES];

  if (BYTES < 1 || BYTES > (1 << AW)) begin : g_check
    $error("record_store: BYTES does not fit AW");
  end

  // whole record loads in one edge so a reader never sees a mix
  // reset loads too: the parent supplies its default image then
  always_ff @(posedge clk) begin
    for (int i = 0; i < BYTES; i++) begin
      if (sys_rst || load) begin
        mem[i] <= load_data[(BYTES-1-i)*8 +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
    end else if (32'(rd_addr) < BYTES) begin
      rd_data <= mem[rd_addr];
    end else begin
      rd_data <= 8'h00;
    end
  end

endmodule : record_store

// *** src/analog_input_diag_records.sv ***
// hardware interrupt and diagnostic records of a two-channel analog input module
module analog_input_diag_records #(
  parameter int CHANNELS = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  // configuration
  input wire logic diag_enable,
  input wire logic limit_enable,
  // measurement side
  input wire logic [1:0] upper_exceed,
  input wire logic [1:0] lower_exceed,
  input wire aidiag_pkg::chan_fault_t ch0_fault,
  input wire aidiag_pkg::chan_fault_t ch1_fault,
  input wire aidiag_pkg::module_fault_t module_fault,
  // record reads
  input wire logic rd_req,
  input wire aidiag_pkg::read_req_t rd_addr,
  output logic rd_valid,
  output logic rd_error,
  output logic [7:0] rd_data,
  // events
  output logic hw_irq,
  output logic diag_irq_incoming,
  output logic diag_irq_going,
  output logic module_fault_led,
  // hardware interrupt record
  output logic [7:0] upper_limit_flags,
  output logic [7:0] lower_limit_flags,
  output logic [15:0] interrupt_timestamp_low
);

  if (CHANNELS != 2) begin : g_check
    $error("analog_input_diag_records: only two channels are served");
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] chan_byte(aidiag_pkg::chan_fault_t f, logic lost);
    logic [7:0] b;
    b = 8'h00;
    b[aidiag_pkg::C_PARAM] = f.param_error;
    b[aidiag_pkg::C_RAW_HIGH] = f.raw_high;
    b[aidiag_pkg::C_RAW_LOW] = f.raw_low;
    b[aidiag_pkg::C_SENSOR] = f.sensor_fault;
    b[aidiag_pkg::C_LOST] = lost;
    b[aidiag_pkg::C_UNDER] = f.range_under;
    b[aidiag_pkg::C_OVER] = f.range_over;
    return b;
  endfunction : chan_byte

  function automatic logic in_range(logic [7:0] idx, int bytes);
    return 32'(idx) < bytes;
  endfunction : in_range

  // ****************************************
  // ticker
  // ****************************************
  logic [31:0] ticker;

  us_ticker #(
    .PRESCALE(aidiag_pkg::TICK_CYCLES)
  ) u_ticker (
    .clk(clk),
    .sys_rst(sys_rst),
    .count(ticker)
  );

  // ****************************************
  // read pipeline, stage one
  // ****************************************
  logic req_q;
  logic err_q;
  logic [7:0] set_q;
  logic [7:0] hw_byte_q;
  logic hw_ack;
  logic diag_ack;
  logic req_ok;
  logic [7:0] set_in;
  logic [7:0] idx_in;

  assign set_in = rd_addr.record_set_index;
  assign idx_in = rd_addr.object_subindex;

  // short and full access to the same snapshot
  always_comb begin
    req_ok = 1'b0;
    if (set_in == aidiag_pkg::SET_SHORT) begin
      req_ok = in_range(idx_in, aidiag_pkg::SHORT_BYTES);
    end else if (set_in == aidiag_pkg::SET_DIAG) begin
      req_ok = in_range(idx_in, aidiag_pkg::DIAG_BYTES);
    end else if (set_in == aidiag_pkg::SET_HW) begin
      req_ok = in_range(idx_in, aidiag_pkg::HW_BYTES);
    end
  end

  // reading the last byte of a record acknowledges it
  assign hw_ack = rd_req && req_ok && set_in == aidiag_pkg::SET_HW
                  && 32'(idx_in) == aidiag_pkg::HW_BYTES - 1;
  assign diag_ack = rd_req && req_ok && set_in == aidiag_pkg::SET_DIAG
                    && 32'(idx_in) == aidiag_pkg::DIAG_BYTES - 1;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_q <= 1'b0;
      err_q <= 1'b0;
      set_q <= 8'h00;
    end else begin
      req_q <= rd_req;
      err_q <= rd_req && !req_ok;
      set_q <= set_in;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hw_byte_q <= 8'h00;
    end else if (rd_req) begin
      unique case (32'(idx_in))
        aidiag_pkg::OFS_HW_UPPER: hw_byte_q <= upper_limit_flags;
        aidiag_pkg::OFS_HW_LOWER: hw_byte_q <= lower_limit_flags;
        aidiag_pkg::OFS_HW_STAMP_HI: hw_byte_q <= interrupt_timestamp_low[15:8];
        aidiag_pkg::OFS_HW_STAMP_LO: hw_byte_q <= interrupt_timestamp_low[7:0];
        default: hw_byte_q <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // read pipeline, stage two
  // ****************************************
  logic [7:0] mem_byte;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_valid <= 1'b0;
      rd_error <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      rd_valid <= req_q;
      rd_error <= err_q;
      if (!req_q || err_q) begin
        rd_data <= 8'h00;
      end else if (set_q == aidiag_pkg::SET_HW) begin
        rd_data <= hw_byte_q;
      end else begin
        rd_data <= mem_byte;
      end
    end
  end

  // ****************************************
  // hardware interrupt record
  // ****************************************
  logic [1:0] upper_prev;
  logic [1:0] lower_prev;
  logic [1:0] up_hit;
  logic [1:0] lo_hit;
  logic hw_pending;
  logic hw_event;
  logic [1:0] ch_lost;

  // crossing edges while monitoring is on
  assign up_hit = limit_enable ? (upper_exceed & ~upper_prev) : 2'b00;
  assign lo_hit = limit_enable ? (lower_exceed & ~lower_prev) : 2'b00;
  assign hw_event = |{up_hit, lo_hit};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      upper_prev <= 2'b00;
      lower_prev <= 2'b00;
    end else begin
      upper_prev <= upper_exceed;
      lower_prev <= lower_exceed;
    end
  end

  // flags and stamp clear at reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      upper_limit_flags <= 8'h00;
      lower_limit_flags <= 8'h00;
      interrupt_timestamp_low <= 16'h0000;
      hw_pending <= 1'b0;
      hw_irq <= 1'b0;
    end else begin
      hw_irq <= 1'b0;
      if (hw_event && (!hw_pending || hw_ack)) begin
        upper_limit_flags <= {6'b000000, up_hit};
        lower_limit_flags <= {6'b000000, lo_hit};
        // low half of ticker at the raise
        interrupt_timestamp_low <= ticker[aidiag_pkg::STAMP_BITS-1:0];
        hw_pending <= 1'b1;
        hw_irq <= 1'b1;
      end else if (hw_ack) begin
        hw_pending <= 1'b0;
      end
    end
  end

  // a crossing while the last record is unread is lost; set beats clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ch_lost <= 2'b00;
    end else begin
      ch_lost <= (diag_ack ? 2'b00 : ch_lost)
                 | ((hw_pending && !hw_ack) ? (up_hit | lo_hit) : 2'b00);
    end
  end

  // ****************************************
  // live diagnostic bytes
  // ****************************************
  logic [7:0] ch_err [2];
  logic [7:0] err_a;
  logic [7:0] err_d;
  logic [7:0] group_err;
  logic cause;

  assign ch_err[0] = chan_byte(ch0_fault, ch_lost[0]);
  assign ch_err[1] = chan_byte(ch1_fault, ch_lost[1]);

  assign group_err = {6'b000000, |ch_err[1], |ch_err[0]};

  always_comb begin
    err_a = 8'h00;
    err_a[aidiag_pkg::A_FAILURE] = module_fault.module_failure;
    err_a[aidiag_pkg::A_INTERNAL] = module_fault.internal_error;
    err_a[aidiag_pkg::A_EXTERNAL] = module_fault.external_error;
    err_a[aidiag_pkg::A_CHANNEL] = |group_err;
    err_a[aidiag_pkg::A_AUX] = module_fault.aux_missing;
    err_a[aidiag_pkg::A_PARAM] = module_fault.param_error
                                 | ch0_fault.param_error | ch1_fault.param_error;
  end

  always_comb begin
    err_d = 8'h00;
    err_d[aidiag_pkg::D_BUF_OVF] = module_fault.buffer_overflow;
    err_d[aidiag_pkg::D_COMM] = module_fault.comm_error;
    err_d[aidiag_pkg::D_LOST] = |ch_lost;
  end

  assign cause = |{err_a, err_d};

  // ****************************************
  // diagnostic sequencing
  // ****************************************
  aidiag_pkg::diag_state_t state;
  logic capture;
  logic [aidiag_pkg::DIAG_BYTES*8-1:0] record;
  logic [aidiag_pkg::DIAG_BYTES*8-1:0] live_record;
  logic [aidiag_pkg::DIAG_BYTES*8-1:0] reset_image;

  // full ticker in the last four bytes
  assign live_record = {err_a, aidiag_pkg::MODULE_INFO, aidiag_pkg::BYTE_ZERO, err_d,
                   aidiag_pkg::CHANNEL_KIND, aidiag_pkg::DIAG_BITS,
                   aidiag_pkg::CHANNEL_COUNT, group_err, ch_err[0], ch_err[1],
                   48'h0000_0000_0000, ticker};

  assign reset_image = {
    aidiag_pkg::BYTE_ZERO,
    aidiag_pkg::MODULE_INFO,
    aidiag_pkg::BYTE_ZERO,
    aidiag_pkg::BYTE_ZERO,
    aidiag_pkg::CHANNEL_KIND,
    aidiag_pkg::DIAG_BITS,
    aidiag_pkg::CHANNEL_COUNT,
    24'h00_0000,
    48'h0000_0000_0000,
    32'h0000_0000
  };

  // constant bytes must read back even before the first event
  assign record = sys_rst ? reset_image : live_record;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= aidiag_pkg::DIAG_IDLE;
      diag_irq_incoming <= 1'b0;
      diag_irq_going <= 1'b0;
    end else begin
      diag_irq_incoming <= 1'b0;
      diag_irq_going <= 1'b0;
      unique case (state)
        aidiag_pkg::DIAG_IDLE: begin
          if (diag_enable && cause) begin
            state <= aidiag_pkg::DIAG_ACTIVE;
            diag_irq_incoming <= 1'b1;
          end
        end
        aidiag_pkg::DIAG_ACTIVE: begin
          if (!cause) begin
            state <= aidiag_pkg::DIAG_IDLE;
            diag_irq_going <= 1'b1;
          end
        end
        default: begin
          state <= aidiag_pkg::DIAG_IDLE;
        end
      endcase
    end
  end

  // snapshot only at incoming and going: events in between are dropped
  assign capture = (state == aidiag_pkg::DIAG_IDLE && diag_enable && cause)
                   || (state == aidiag_pkg::DIAG_ACTIVE && !cause);

  // lit for the whole active window
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      module_fault_led <= 1'b0;
    end else begin
      module_fault_led <= (state == aidiag_pkg::DIAG_IDLE) ? (diag_enable && cause) : cause;
    end
  end

  // record served from the snapshot store
  record_store #(
    .BYTES(aidiag_pkg::DIAG_BYTES),
    .AW(5)
  ) u_store (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(capture),
    .load_data(record),
    .rd_addr(idx_in[4:0]),
    .rd_data(mem_byte)
  );

endmodule : analog_input_diag_records

// *** verif/aidiag_asserts.sv ***
// port checker for the analog input record block
module aidiag_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic diag_enable,
  input wire logic limit_enable,
  input wire logic [1:0] upper_exceed,
  input wire logic [1:0] lower_exceed,
  input wire aidiag_pkg::chan_fault_t ch0_fault,
  input wire aidiag_pkg::chan_fault_t ch1_fault,
  input wire aidiag_pkg::module_fault_t module_fault,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic rd_error,
  input wire logic [7:0] rd_data,
  input wire logic hw_irq,
  input wire logic diag_irq_incoming,
  input wire logic diag_irq_going,
  input wire logic module_fault_led,
  input wire logic [7:0] upper_limit_flags,
  input wire logic [7:0] lower_limit_flags,
  input wire logic [15:0] interrupt_timestamp_low
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****
  // read port
  // ****
  property p_rd_latency;
    rd_req |-> ##2 rd_valid;
  endproperty
  a_rd_latency: assert property (p_rd_latency) else $error("read answer late");
  property p_rd_cause;
    rd_valid |-> $past(rd_req, 2);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("answer without request");
  property p_rd_refused;
    rd_valid && rd_error |-> rd_data == 8'h00;
  endproperty
  a_rd_refused: assert property (p_rd_refused) else $error("refused read with data");
  // ****
  // hardware interrupt
  // ****
  property p_hw_upper;
    hw_irq |-> upper_limit_flags == {6'h00, $past(upper_exceed) & ~$past(upper_exceed, 2)};
  endproperty
  a_hw_upper: assert property (p_hw_upper) else $error("upper flags wrong");
  property p_hw_lower;
    hw_irq |-> lower_limit_flags == {6'h00, $past(lower_exceed) & ~$past(lower_exceed, 2)};
  endproperty
  a_hw_lower: assert property (p_hw_lower) else $error("lower flags wrong");
  property p_hw_enable;
    hw_irq |-> $past(limit_enable);
  endproperty
  a_hw_enable: assert property (p_hw_enable) else $error("interrupt while disabled");
  property p_hw_hold;
    !hw_irq |-> $stable(upper_limit_flags) && $stable(lower_limit_flags)
      && $stable(interrupt_timestamp_low);
  endproperty
  a_hw_hold: assert property (p_hw_hold) else $error("record moved without event");
  // ****
  // diagnostic events
  // ****
  property p_led_on;
    diag_irq_incoming |-> module_fault_led && !$past(module_fault_led);
  endproperty
  a_led_on: assert property (p_led_on) else $error("led not lit on incoming");
  property p_led_off;
    diag_irq_going |-> !module_fault_led && $past(module_fault_led);
  endproperty
  a_led_off: assert property (p_led_off) else $error("led not dark on going");
  property p_led_steady;
    !diag_irq_incoming && !diag_irq_going |-> $stable(module_fault_led);
  endproperty
  a_led_steady: assert property (p_led_steady) else $error("led moved alone");
  property p_diag_enable;
    diag_irq_incoming |-> $past(diag_enable);
  endproperty
  a_diag_enable: assert property (p_diag_enable) else $error("incoming while off");
  property p_going_clear;
    diag_irq_going |-> $past(module_fault) == '0 && $past(ch0_fault) == '0
      && $past(ch1_fault) == '0;
  endproperty
  a_going_clear: assert property (p_going_clear) else $error("going with cause");
  c_hw: cover property (hw_irq);
  c_in: cover property (diag_irq_incoming);
  c_out: cover property (diag_irq_going);
  c_ref: cover property (rd_valid && rd_error);
endmodule : aidiag_asserts

bind analog_input_diag_records aidiag_asserts u_chk (
  .clk(clk), .sys_rst(sys_rst), .diag_enable(diag_enable), .limit_enable(limit_enable),
  .upper_exceed(upper_exceed), .lower_exceed(lower_exceed), .ch0_fault(ch0_fault),
  .ch1_fault(ch1_fault), .module_fault(module_fault), .rd_req(rd_req),
  .rd_valid(rd_valid), .rd_error(rd_error), .rd_data(rd_data), .hw_irq(hw_irq),
  .diag_irq_incoming(diag_irq_incoming), .diag_irq_going(diag_irq_going),
  .module_fault_led(module_fault_led), .upper_limit_flags(upper_limit_flags),
  .lower_limit_flags(lower_limit_flags), .interrupt_timestamp_low(interrupt_timestamp_low)
);

// *** verif/record_host.sv ***
// host side reader that fetches record bytes over the read port
module record_host (
  input wire logic clk,
  input wire logic rd_valid,
  input wire logic rd_error,
  input wire logic [7:0] rd_data,
  output logic rd_req,
  output aidiag_pkg::read_req_t rd_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rd_req = 1'b0;
    rd_addr = '0;
  end
  task automatic fetch(input logic [7:0] set, input logic [7:0] idx, output logic [7:0] data,
    output logic err, output int lat);
    @(posedge clk);
    rd_req <= 1'b1;
    rd_addr <= {set, idx};
    lat = 0;
    data = 8'h00;
    err = 1'b1;
    for (int n = 1; n <= 4; n++) begin
      @(posedge clk);
      rd_req <= 1'b0;
      // address is junk once the pulse is gone
      rd_addr <= ~rd_addr;
      #1;
      if (rd_valid === 1'b1 && lat == 0) begin
        lat = n;
        data = rd_data;
        err = rd_error;
      end
    end
  endtask : fetch
endmodule : record_host

// *** verif/analog_input_diag_records_bench.sv ***
// self-checking bench for the analog input record block
module analog_input_diag_records_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, diag_enable, limit_enable, rd_req, rd_valid, rd_error, hw_irq, e;
  logic diag_irq_incoming, diag_irq_going, module_fault_led;
  logic [1:0] upper_exceed, lower_exceed;
  aidiag_pkg::chan_fault_t ch0_fault, ch1_fault;
  aidiag_pkg::module_fault_t module_fault;
  aidiag_pkg::read_req_t rd_addr;
  logic [7:0] rd_data, upper_limit_flags, lower_limit_flags, d;
  logic [15:0] interrupt_timestamp_low, lfsr;
  logic [15:0] bad [4] = '{16'h0004, 16'h0114, 16'h0204, 16'h0300};
  logic [7:0] exp_rec [20];
  int n_fail, compares, lat, at, rel, stamp_exp;
  int cyc = 0;
  analog_input_diag_records u_dut (.clk(clk), .sys_rst(sys_rst), .diag_enable(diag_enable),
    .limit_enable(limit_enable), .upper_exceed(upper_exceed), .lower_exceed(lower_exceed),
    .ch0_fault(ch0_fault), .ch1_fault(ch1_fault), .module_fault(module_fault),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_error(rd_error),
    .rd_data(rd_data), .hw_irq(hw_irq), .diag_irq_incoming(diag_irq_incoming),
    .diag_irq_going(diag_irq_going), .module_fault_led(module_fault_led),
    .upper_limit_flags(upper_limit_flags), .lower_limit_flags(lower_limit_flags),
    .interrupt_timestamp_low(interrupt_timestamp_low));
  record_host u_host (.clk(clk), .rd_valid(rd_valid), .rd_error(rd_error), .rd_data(rd_data),
    .rd_req(rd_req), .rd_addr(rd_addr));
  // ****
  // helpers
  // ****
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : step
  // ticker phase is not visible, so allow a little slack
  function automatic logic near(input logic [31:0] s, input int x);
    return (s + 32'd2 >= 32'(x)) && (s <= 32'(x + 2));
  endfunction : near
  function automatic logic [7:0] chb(input aidiag_pkg::chan_fault_t f, input logic lost);
    return {f.range_over, f.range_under, lost, f.sensor_fault, 1'b0, f.raw_low, f.raw_high,
      f.param_error};
  endfunction : chb
  task automatic model(input logic l0, input logic l1);
    logic [7:0] b0;
    logic [7:0] b1;
    b0 = chb(ch0_fault, l0);
    b1 = chb(ch1_fault, l1);
    exp_rec = '{default: 8'h00};
    exp_rec[0] = {module_fault.param_error | b0[0] | b1[0], 2'b00, module_fault.aux_missing,
      |{b0, b1}, module_fault.external_error, module_fault.internal_error,
      module_fault.module_failure};
    exp_rec[1] = 8'h15;
    exp_rec[3] = {1'b0, l0 | l1, 1'b0, module_fault.comm_error, module_fault.buffer_overflow,
      3'b000};
    exp_rec[4] = 8'h71;
    exp_rec[5] = 8'h08;
    exp_rec[6] = 8'h02;
    exp_rec[7] = {6'h00, |b1, |b0};
    exp_rec[8] = b0;
    exp_rec[9] = b1;
  endtask : model
  task automatic read_diag(input logic [7:0] set, input int n);
    logic [31:0] st;
    st = 32'h0;
    for (int i = 0; i < n; i++) begin
      u_host.fetch(set, 8'(i), d, e, lat);
      check("read latency", lat, 2);
      if (i < 16) check("diag byte", d, exp_rec[i]);
      else st = {st[23:0], d};
    end
    if (n == 20) check("diag stamp", near(st, stamp_exp), 1);
  endtask : read_diag
  task automatic wait_evt(input int k, output int t);
    t = -1;
    for (int i = 0; i < 30 && t < 0; i++) begin
      @(posedge clk);
      #1;
      if ((k == 0 ? hw_irq : k == 1 ? diag_irq_incoming : diag_irq_going) === 1'b1) t = cyc;
    end
  endtask : wait_evt
  // ****
  // main sequence
  // ****
  initial begin
    sys_rst = 1'b1;
    diag_enable = 1'b0;
    limit_enable = 1'b0;
    upper_exceed = 2'b00;
    lower_exceed = 2'b00;
    ch0_fault = '0;
    ch1_fault = '0;
    module_fault = '0;
    n_fail = 0;
    compares = 0;
    lfsr = 16'h0059;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    rel = cyc;
    check("reset flags", {upper_limit_flags, lower_limit_flags, interrupt_timestamp_low}, 0);
    model(1'b0, 1'b0);
    stamp_exp = 0;
    read_diag(8'h01, 20);
    read_diag(8'h00, 4);
    for (int i = 0; i < 4; i++) begin
      u_host.fetch(bad[i][15:8], bad[i][7:0], d, e, lat);
      check("refused", {e, d}, 9'h100);
      check("refused latency", lat, 2);
    end
    @(posedge clk);
    upper_exceed <= 2'b01;
    wait_evt(0, at);
    check("hw off", at, -1);
    @(posedge clk);
    upper_exceed <= 2'b00;
    limit_enable <= 1'b1;
    @(posedge clk);
    upper_exceed <= 2'b10;
    lower_exceed <= 2'b01;
    wait_evt(0, at);
    check("upper", upper_limit_flags, 8'h02);
    check("lower", lower_limit_flags, 8'h01);
    check("hw stamp", near(interrupt_timestamp_low, (at - rel) / 10), 1);
    @(posedge clk);
    upper_exceed <= 2'b11;
    wait_evt(0, at);
    check("hw pending", at, -1);
    for (int i = 0; i < 4; i++) begin
      u_host.fetch(8'h02, 8'(i), d, e, lat);
      if (i < 2) check("hw byte", d, 8'h02 >> i);
    end
    @(posedge clk);
    lower_exceed <= 2'b11;
    wait_evt(0, at);
    check("new bits", {upper_limit_flags, lower_limit_flags}, 16'h0002);
    @(posedge clk);
    upper_exceed <= 2'b00;
    lower_exceed <= 2'b00;
    diag_enable <= 1'b1;
    wait_evt(1, at);
    check("lost incoming", at >= 0, 1);
    model(1'b1, 1'b0);
    stamp_exp = (at - rel) / 10;
    read_diag(8'h01, 20);
    check("led dark", module_fault_led, 0);
    for (int k = 0; k < 4; k++) begin
      lfsr = step(lfsr);
      @(posedge clk);
      ch0_fault <= lfsr[5:0];
      ch1_fault <= lfsr[11:6];
      module_fault <= {lfsr[15:12], lfsr[2:0]} | 7'h01;
      wait_evt(1, at);
      check("incoming", at >= 0, 1);
      check("led lit", module_fault_led, 1);
      model(1'b0, 1'b0);
      stamp_exp = (at - rel) / 10;
      @(posedge clk);
      ch0_fault <= ~ch0_fault;
      read_diag(8'h01, 20);
      @(posedge clk);
      ch0_fault <= '0;
      ch1_fault <= '0;
      module_fault <= '0;
      wait_evt(2, at);
      check("going", at >= 0, 1);
      check("led off", module_fault_led, 0);
    end
    @(posedge clk);
    diag_enable <= 1'b0;
    module_fault <= 7'h40;
    wait_evt(1, at);
    check("diag off", at, -1);
    stop_test();
  end
endmodule : analog_input_diag_records_bench
